// File: core/sdp_regs.vh
// Purpose: Register map, field positions, reset values and timing counts
//          of the stereo playback path
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef SDP_REGS_VH
`define SDP_REGS_VH
// Register byte offsets
`define SDP_DAC_CTRL_OFS 8'h00
`define SDP_ATT_L_OFS 8'h04
`define SDP_ATT_R_OFS 8'h08
`define SDP_EQ_OFS 8'h0C
`define SDP_MIC_AUX_OFS 8'h10
`define SDP_STATUS_OFS 8'h14
// Control register fields
`define SDP_DEEMPH_LSB 0
`define SDP_EQ_ON_BIT 2
`define SDP_GANG_BIT 4
`define SDP_SOFT_MUTE_REQ_BIT 5
`define SDP_RAMP_BIT 6
// Mic and aux register fields
`define SDP_PREAMP_LSB 0
`define SDP_ZTO_LSB 8
`define SDP_ALC_BIT 10
`define SDP_AUX_SE_BIT 12
`define SDP_AUX_GAIN_LSB 16
// Reset values
`define SDP_DAC_CTRL_RST 7'h01
`define SDP_ATT_RST 8'h00
`define SDP_EQ_RST 20'h88888
`define SDP_PREAMP_RST 7'h10
`define SDP_ZTO_RST 2'h0
`define SDP_AUX_GAIN_RST 4'h7
// De-emphasis curve codes
`define SDP_DEM_441 2'h0
`define SDP_DEM_OFF 2'h1
`define SDP_DEM_48 2'h2
`define SDP_DEM_32 2'h3
// Attenuator codes and ramp timing in sample periods
`define SDP_ATT_MUTE 8'hFF
`define SDP_ATT_STEPS 255
`define SDP_RAMP_SLOW_FS 1061
`define SDP_RAMP_FAST_FS 256
`define SDP_ZC_BASE_FS 128
// FIFO shape
`define SDP_FIFO_WIDTH 32
`define SDP_FIFO_DEPTH 16
`define SDP_FIFO_AW 4
`endif

// File: core/sdp_top.v
// Operation
// - Two-bit de-emphasis select: 00 44.1k, 01 off (reset), 10 48k, 11 32k.
// - Eight-bit attenuator per channel, 0.5dB steps from 0dB, FFH mutes.
// - Gang bit set: left code drives both channels; clear: separate codes.
// - Level changes ramp: full sweep about 1061/fs slow, 256/fs fast.
// - Five equalizer bands, 100Hz to 10kHz at 44.1k, scaling with fs.
// - Lowest and highest bands shelve; three middle bands peak.
// - Enable bit switches equalizer; code 0H +12dB, 1.5dB per code, 8H flat.
// - Soft mute request ramps attenuation down to silence at ramp speed.
// - Releasing soft mute ramps back to the programmed attenuation.
// - Early release of mute stops and ramps back from the point reached.
// - Mute ramp is shorter when programmed attenuation is already higher.
// - New preamp gain applies at zero crossing or timeout, whichever first.
// - Aux select 0 differential, 1 single-ended using positive pin only.
// - Aux gain code FH +24dB, 3dB per code, 7H 0dB reset, 0H -21dB.
//
// Purpose: Digital playback path with APB registers and a sample FIFO
// Assumes: fs_tick is a one-cycle pulse per sample period, synchronous inputs
// Notes:   Analog gain fields are passed out as registered codes
`timescale 1ns/1ps
`include "sdp_regs.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Sample FIFO with registered flags
module sdp_fifo #(
    parameter WIDTH = `SDP_FIFO_WIDTH,
    parameter DEPTH = `SDP_FIFO_DEPTH,
    parameter AW = `SDP_FIFO_AW
) (
    input wire clock,
    input wire rst_b,
    input wire wr_valid,
    output reg wr_ready,
    input wire [WIDTH-1:0] wr_data,
    output wire rd_valid,
    input wire rd_ready,
    output wire [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] rptr_reg;
    reg [AW:0] count_reg;
    reg rd_valid_reg;
    wire push;
    wire pop;
    wire [AW:0] count_next;

    // Handshakes and occupancy
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid_reg && rd_ready;
    assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign rd_valid = rd_valid_reg;
    assign rd_data = mem[rptr_reg];

    // Storage
    always @(posedge clock) begin
        if (push) begin
            mem[wptr_reg] <= wr_data;
        end
    end

    // Pointers and flags
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            wr_ready <= 1'b0;
            rd_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            count_reg <= count_next;
            wr_ready <= (count_next < DEPTH);
            rd_valid_reg <= (count_next != {(AW+1){1'b0}});
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Playback path top
module sdp_top (
    input wire clock,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire fs_tick,
    input wire in_valid,
    output wire in_ready,
    input wire [15:0] in_left,
    input wire [15:0] in_right,
    output reg out_valid,
    input wire out_ready,
    output reg [15:0] out_left,
    output reg [15:0] out_right,
    input wire mic_sign,
    output reg [6:0] preamp_gain,
    output reg auto_level_enable,
    output reg aux_single_ended,
    output reg aux_neg_pin_en,
    output reg [3:0] aux_gain_code
);
    localparam [31:0] SLOW_IVL = `SDP_RAMP_SLOW_FS / `SDP_ATT_STEPS;
    localparam [31:0] FAST_IVL = `SDP_RAMP_FAST_FS / `SDP_ATT_STEPS;
    localparam [31:0] ZC_N = `SDP_ZC_BASE_FS;

    reg [6:0] dac_ctrl_reg;
    reg [7:0] left_atten_code;
    reg [7:0] right_atten_code;
    reg [19:0] eq_reg;
    reg [6:0] preamp_gain_code;
    reg [1:0] zero_cross_timeout_sel;
    reg [7:0] eff_att_reg [0:1];
    reg [2:0] ramp_cnt_reg;
    reg preamp_pend_reg;
    reg mic_sign_reg;
    reg [10:0] zc_cnt_reg;
    reg signed [23:0] lp_reg [0:7];
    reg signed [23:0] de_reg [0:1];
    reg signed [23:0] lp_next [0:7];
    reg signed [23:0] de_next [0:1];
    reg [15:0] res_next [0:1];
    reg signed [23:0] x;
    reg signed [23:0] y;
    reg signed [23:0] band;
    reg signed [23:0] acc;
    reg [7:0] att_target [0:1];
    reg [7:0] coef;
    integer c;
    integer i;
    integer j;
    integer k;
    wire [31:0] fifo_data;
    wire fifo_valid;
    wire fifo_pop;
    wire wr_en;
    wire [1:0] deemph_curve_sel;
    wire equalizer_on;
    wire atten_gang;
    wire soft_mute_req;
    wire ramp_speed_sel;
    wire [10:0] zc_limit;

    assign deemph_curve_sel = dac_ctrl_reg[`SDP_DEEMPH_LSB+1:`SDP_DEEMPH_LSB];
    assign equalizer_on = dac_ctrl_reg[`SDP_EQ_ON_BIT];
    assign atten_gang = dac_ctrl_reg[`SDP_GANG_BIT];
    assign soft_mute_req = dac_ctrl_reg[`SDP_SOFT_MUTE_REQ_BIT];
    assign ramp_speed_sel = dac_ctrl_reg[`SDP_RAMP_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    // Q8 gain multiply
    function signed [23:0] gmul;
        input signed [23:0] v;
        input [9:0] g;
        reg signed [34:0] p;
        begin
            p = v * $signed({1'b0, g});
            gmul = p[31:8];
        end
    endfunction

    // Equalizer code to Q8 linear gain, 1.5dB per code
    function [9:0] eq_gain;
        input [3:0] code;
        begin
            case (code)
                4'h0: eq_gain = 10'h3FB;
                4'h1: eq_gain = 10'h35A;
                4'h2: eq_gain = 10'h2D1;
                4'h3: eq_gain = 10'h25F;
                4'h4: eq_gain = 10'h1FF;
                4'h5: eq_gain = 10'h1AE;
                4'h6: eq_gain = 10'h16A;
                4'h7: eq_gain = 10'h130;
                4'h8: eq_gain = 10'h100;
                4'h9: eq_gain = 10'h0D7;
                4'hA: eq_gain = 10'h0B5;
                4'hB: eq_gain = 10'h098;
                4'hC: eq_gain = 10'h080;
                4'hD: eq_gain = 10'h06C;
                4'hE: eq_gain = 10'h05B;
                default: eq_gain = 10'h04C;
            endcase
        end
    endfunction

    // Attenuator: 0.5dB mantissa then 6dB shifts, mute at FFH
    function signed [23:0] atten;
        input signed [23:0] v;
        input [7:0] code;
        reg [9:0] m;
        reg signed [23:0] s;
        begin
            case (code % 12)
                0: m = 10'h100;
                1: m = 10'h0F2;
                2: m = 10'h0E4;
                3: m = 10'h0D7;
                4: m = 10'h0CB;
                5: m = 10'h0C0;
                6: m = 10'h0B5;
                7: m = 10'h0AB;
                8: m = 10'h0A1;
                9: m = 10'h098;
                10: m = 10'h090;
                default: m = 10'h088;
            endcase
            s = gmul(v, m) >>> (code / 12);
            atten = (code == `SDP_ATT_MUTE) ? 24'h000000 : s;
        end
    endfunction

    // Saturate to 16 bits
    function [15:0] sat16;
        input signed [23:0] v;
        begin
            if (v > 24'sh007FFF) begin
                sat16 = 16'h7FFF;
            end else if (v < -24'sh008000) begin
                sat16 = 16'h8000;
            end else begin
                sat16 = v[15:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sample FIFO; drained only when the output holder is free
    sdp_fifo #(
        .WIDTH(`SDP_FIFO_WIDTH),
        .DEPTH(`SDP_FIFO_DEPTH),
        .AW(`SDP_FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .wr_valid(in_valid),
        .wr_ready(in_ready),
        .wr_data({in_left, in_right}),
        .rd_valid(fifo_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_data)
    );

    assign fifo_pop = fifo_valid && (!out_valid || out_ready);

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel filter chain
    always @* begin
        x = 24'sh000000;
        y = 24'sh000000;
        band = 24'sh000000;
        acc = 24'sh000000;
        coef = 8'h00;
        // Curve coefficient per sampling rate
        case (deemph_curve_sel)
            `SDP_DEM_441: coef = 8'h50;
            `SDP_DEM_48: coef = 8'h4B;
            `SDP_DEM_32: coef = 8'h64;
            default: coef = 8'h00;
        endcase
        for (c = 0; c < 2; c = c + 1) begin
            if (c == 0) begin
                x = {{8{fifo_data[31]}}, fifo_data[31:16]};
            end else begin
                x = {{8{fifo_data[15]}}, fifo_data[15:0]};
            end
            // De-emphasis shelf: smoothed path blended with the input
            de_next[c] = de_reg[c] + gmul(x - de_reg[c], {2'b00, coef});
            if (deemph_curve_sel != `SDP_DEM_OFF) begin
                y = de_next[c] + ((x - de_next[c]) >>> 2);
            end else begin
                y = x;
            end
            // One-pole splits, shift sets corner relative to fs
            lp_next[c*4] = lp_reg[c*4] + ((y - lp_reg[c*4]) >>> 6);
            lp_next[c*4+1] = lp_reg[c*4+1] + ((y - lp_reg[c*4+1]) >>> 5);
            lp_next[c*4+2] = lp_reg[c*4+2] + ((y - lp_reg[c*4+2]) >>> 3);
            lp_next[c*4+3] = lp_reg[c*4+3] + ((y - lp_reg[c*4+3]) >>> 1);
            // Low shelf, three peaks, high shelf
            acc = gmul(lp_next[c*4], eq_gain(eq_reg[3:0]));
            for (i = 1; i < 4; i = i + 1) begin
                band = lp_next[c*4+i] - lp_next[c*4+i-1];
                acc = acc + gmul(band, eq_gain(eq_reg[i*4+:4]));
            end
            acc = acc + gmul(y - lp_next[c*4+3], eq_gain(eq_reg[19:16]));
            if (equalizer_on) begin
                y = acc;
            end
            res_next[c] = sat16(atten(y, eff_att_reg[c]));
        end
    end

    // Filter state and output holder
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (j = 0; j < 8; j = j + 1) begin
                lp_reg[j] <= 24'sh000000;
            end
            de_reg[0] <= 24'sh000000;
            de_reg[1] <= 24'sh000000;
            out_valid <= 1'b0;
            out_left <= 16'h0000;
            out_right <= 16'h0000;
        end else begin
            if (fifo_pop) begin
                for (j = 0; j < 8; j = j + 1) begin
                    lp_reg[j] <= lp_next[j];
                end
                de_reg[0] <= de_next[0];
                de_reg[1] <= de_next[1];
                out_left <= res_next[0];
                out_right <= res_next[1];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Attenuation targets: mute wins, else programmed or ganged code
    always @* begin
        att_target[0] = soft_mute_req ? `SDP_ATT_MUTE : left_atten_code;
        if (soft_mute_req) begin
            att_target[1] = `SDP_ATT_MUTE;
        end else if (atten_gang) begin
            att_target[1] = left_atten_code;
        end else begin
            att_target[1] = right_atten_code;
        end
    end

    // Ramp one code per interval from wherever the level stands
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            eff_att_reg[0] <= `SDP_ATT_RST;
            eff_att_reg[1] <= `SDP_ATT_RST;
            ramp_cnt_reg <= 3'h0;
        end else if (fs_tick) begin
            if (ramp_cnt_reg == 3'h0) begin
                ramp_cnt_reg <= (ramp_speed_sel ? FAST_IVL[2:0] : SLOW_IVL[2:0]) - 3'h1;
                for (k = 0; k < 2; k = k + 1) begin
                    // Remaining distance sets ramp length
                    if (eff_att_reg[k] < att_target[k]) begin
                        eff_att_reg[k] <= eff_att_reg[k] + 8'h01;
                    end else if (eff_att_reg[k] > att_target[k]) begin
                        eff_att_reg[k] <= eff_att_reg[k] - 8'h01;
                    end
                end
            end else begin
                ramp_cnt_reg <= ramp_cnt_reg - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Preamp gain follows code at zero crossing or timeout
    assign zc_limit = ZC_N[10:0] << zero_cross_timeout_sel;
    assign wr_en = psel && penable && pwrite && pready;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            preamp_gain <= `SDP_PREAMP_RST;
            preamp_pend_reg <= 1'b0;
            mic_sign_reg <= 1'b0;
            zc_cnt_reg <= 11'h000;
        end else begin
            if (fs_tick) begin
                mic_sign_reg <= mic_sign;
            end
            if (wr_en && paddr == `SDP_MIC_AUX_OFS) begin
                // A fresh write restarts the wait (the write wins)
                preamp_pend_reg <= 1'b1;
                zc_cnt_reg <= 11'h000;
            end else if (preamp_pend_reg && fs_tick) begin
                if (mic_sign != mic_sign_reg || zc_cnt_reg + 11'h001 >= zc_limit) begin
                    preamp_gain <= preamp_gain_code;
                    preamp_pend_reg <= 1'b0;
                    zc_cnt_reg <= 11'h000;
                end else begin
                    zc_cnt_reg <= zc_cnt_reg + 11'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, writes at the completing edge
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            dac_ctrl_reg <= `SDP_DAC_CTRL_RST;
            left_atten_code <= `SDP_ATT_RST;
            right_atten_code <= `SDP_ATT_RST;
            eq_reg <= `SDP_EQ_RST;
            preamp_gain_code <= `SDP_PREAMP_RST;
            zero_cross_timeout_sel <= `SDP_ZTO_RST;
            auto_level_enable <= 1'b0;
            aux_single_ended <= 1'b0;
            aux_neg_pin_en <= 1'b1;
            aux_gain_code <= `SDP_AUX_GAIN_RST;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                // Decode for the answer
                prdata <= 32'h00000000;
                case (paddr)
                    `SDP_DAC_CTRL_OFS: prdata <= {25'h0, dac_ctrl_reg};
                    `SDP_ATT_L_OFS: prdata <= {24'h000000, left_atten_code};
                    `SDP_ATT_R_OFS: prdata <= {24'h000000, right_atten_code};
                    `SDP_EQ_OFS: prdata <= {12'h000, eq_reg};
                    `SDP_MIC_AUX_OFS: prdata <= {12'h000, aux_gain_code, 3'h0,
                        aux_single_ended, 1'b0, auto_level_enable,
                        zero_cross_timeout_sel, 1'b0, preamp_gain_code};
                    `SDP_STATUS_OFS: prdata <= {8'h00, 1'b0, preamp_gain,
                        eff_att_reg[1], eff_att_reg[0]};
                    default: pslverr <= 1'b1;
                endcase
            end
            if (wr_en) begin
                case (paddr)
                    `SDP_DAC_CTRL_OFS: dac_ctrl_reg <= pwdata[6:0];
                    `SDP_ATT_L_OFS: left_atten_code <= pwdata[7:0];
                    `SDP_ATT_R_OFS: right_atten_code <= pwdata[7:0];
                    `SDP_EQ_OFS: eq_reg <= pwdata[19:0];
                    `SDP_MIC_AUX_OFS: begin
                        preamp_gain_code <= pwdata[`SDP_PREAMP_LSB+6:`SDP_PREAMP_LSB];
                        zero_cross_timeout_sel <= pwdata[`SDP_ZTO_LSB+1:`SDP_ZTO_LSB];
                        auto_level_enable <= pwdata[`SDP_ALC_BIT];
                        aux_single_ended <= pwdata[`SDP_AUX_SE_BIT];
                        aux_neg_pin_en <= !pwdata[`SDP_AUX_SE_BIT];
                        aux_gain_code <= pwdata[`SDP_AUX_GAIN_LSB+3:`SDP_AUX_GAIN_LSB];
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/sdp_checker.sv
// Purpose: Port-level assertions for the playback path
// Assumes: Sees only the ports of sdp_top, one clock domain
// Notes:   Bound to every sdp_top instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module sdp_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fs_tick,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [15:0] out_left,
    input wire logic [15:0] out_right,
    input wire logic [6:0] preamp_gain,
    input wire logic aux_single_ended,
    input wire logic aux_neg_pin_en,
    input wire logic [3:0] aux_gain_code
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // Register bus handshake
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    chk_ready_cause: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    chk_err_qual: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    ////////////////////////////////////////////////////////////////////////////
    // Sample output and analog control codes
    chk_out_hold: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_left) && $stable(out_right))
        else $error("output sample dropped or changed while stalled");
    chk_gain_tick: assert property ($changed(preamp_gain) |-> $past(fs_tick))
        else $error("preamp gain changed away from a sample strobe");
    chk_aux_pins: assert property (aux_neg_pin_en == !aux_single_ended)
        else $error("negative aux pin use disagrees with input mode");
    chk_aux_gain_src: assert property ($changed(aux_gain_code) |->
        $past(pready && pwrite))
        else $error("aux gain code changed without a register write");
endmodule

bind sdp_top sdp_checker chk (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .fs_tick(fs_tick),
    .out_valid(out_valid), .out_ready(out_ready), .out_left(out_left),
    .out_right(out_right), .preamp_gain(preamp_gain), .aux_single_ended(aux_single_ended),
    .aux_neg_pin_en(aux_neg_pin_en), .aux_gain_code(aux_gain_code));
`default_nettype wire

// File: verif/sdp_far_end.sv
// Purpose: Model of the serial port side: sample strobe and output sink
// Assumes: Strobe period FS_DIV clocks; sink mode 0 ready, 1 random, 2 stalled
// Notes:   Random stalls draw on this module's own $urandom stream
`timescale 1ns/1ps
`default_nettype none
module sdp_far_end #(
    parameter int FS_DIV = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [1:0] sink_mode,
    output logic fs_tick,
    output logic out_ready
);
    int cnt;
    // Sample strobe and sink acceptance
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            fs_tick <= 1'b0;
            out_ready <= 1'b0;
        end else begin
            cnt <= (cnt == FS_DIV - 1) ? 0 : cnt + 1;
            fs_tick <= (cnt == FS_DIV - 1);
            out_ready <= (sink_mode == 2'h0) || (sink_mode == 2'h1 && $urandom % 2 == 0);
        end
    end
endmodule
`default_nettype wire

// File: verif/stereo_dac_digital_path_test.sv
// Purpose: Self-checking bench for the playback path
// Assumes: APB master tasks, far-end model drives strobe and sink
// Notes:   Expected samples queued at input, compared at output
`timescale 1ns/1ps
`default_nettype none
module stereo_dac_digital_path_test;
    logic clock, rst_b, psel, penable, pwrite, in_valid, mic_sign, pready, pslverr, rd_err;
    logic fs_tick, in_ready, out_valid, out_ready, auto_level_enable, aux_single_ended;
    logic aux_neg_pin_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed_val;
    logic [15:0] in_left, in_right, out_left, out_right;
    logic [6:0] preamp_gain;
    logic [3:0] aux_gain_code;
    logic [1:0] sink_mode;
    logic [31:0] exp_q[$];
    int err_total, cmp_count, acc, cyc;

    sdp_top dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fs_tick(fs_tick), .in_valid(in_valid), .in_ready(in_ready),
        .in_left(in_left), .in_right(in_right), .out_valid(out_valid),
        .out_ready(out_ready), .out_left(out_left), .out_right(out_right),
        .mic_sign(mic_sign), .preamp_gain(preamp_gain),
        .auto_level_enable(auto_level_enable), .aux_single_ended(aux_single_ended),
        .aux_neg_pin_en(aux_neg_pin_en), .aux_gain_code(aux_gain_code));
    sdp_far_end #(.FS_DIV(16)) far (.clock(clock), .rst_b(rst_b), .sink_mode(sink_mode),
        .fs_tick(fs_tick), .out_ready(out_ready));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clock iff fs_tick === 1'b1);
    endtask
    // Offer n samples, stop at a refusal
    task automatic stream(input int n, input bit zero);
        logic [31:0] d;
        acc = 0;
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            in_valid <= 1'b1;
            {in_left, in_right} <= d;
            @(posedge clock);
            if (in_ready !== 1'b1) break;
            exp_q.push_back(zero ? 32'h0 : d);
            acc++;
        end
        in_valid <= 1'b0;
    endtask
    task automatic drain();
        for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge clock);
        check(exp_q.size(), 32'h0);
    endtask
    // Count strobes until an effective attenuation lane reaches its target
    task automatic wait_eff(input int sh, input logic [7:0] t, input int lo, input int hi);
        int k;
        k = 0;
        do begin
            ticks(1);
            apb(1'b0, 8'h14, 32'h0);
            k++;
        end while (rd[sh +: 8] !== t && k < 400);
        check({31'h0, k >= lo && k <= hi}, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and output monitor
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            close_out();
        end
    end
    always @(posedge clock) begin
        if (rst_b && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check({out_left, out_right}, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_b, psel, penable, pwrite, in_valid, mic_sign, paddr, pwdata} = '0;
        {in_left, in_right, sink_mode, rd, rd_err} = '0;
        seed_val = $urandom(65);
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, 8'h00, 32'h0); check(rd, 32'h1);
        apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0); check(rd, 32'h88888);
        apb(1'b0, 8'h10, 32'h0); check(rd, 32'h70010);
        apb(1'b1, 8'h3C, 32'h5); check({31'h0, rd_err}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, i);
            apb(1'b0, 8'h00, 32'h0); check(rd, i);
        end
        apb(1'b1, 8'h0C, 32'hF0A18);
        apb(1'b0, 8'h0C, 32'h0); check(rd, 32'hF0A18);
        apb(1'b1, 8'h0C, 32'h88888);
        apb(1'b1, 8'h00, 32'h41);
        stream(8, 1'b0);
        drain();
        // Fill the buffer against a stalled sink, then drain with random stalls
        apb(1'b1, 8'h00, 32'h45);
        sink_mode <= 2'h2;
        stream(24, 1'b0); check({31'h0, acc >= 16 && acc <= 18}, 32'h1);
        sink_mode <= 2'h1;
        drain();
        sink_mode <= 2'h0;
        // Fast ramps, ganged and separate channels
        apb(1'b1, 8'h04, 32'h20);
        wait_eff(0, 8'h20, 30, 34);
        apb(1'b1, 8'h00, 32'h51);
        wait_eff(8, 8'h20, 30, 34);
        apb(1'b1, 8'h00, 32'h41);
        wait_eff(8, 8'h00, 30, 34);
        apb(1'b0, 8'h08, 32'h0); check(rd, 32'h0);
        // Soft mute from a programmed level, full and early release
        apb(1'b1, 8'h00, 32'h61);
        wait_eff(0, 8'hFF, 220, 226);
        wait_eff(8, 8'hFF, 0, 40);
        stream(4, 1'b1);
        drain();
        apb(1'b1, 8'h00, 32'h41);
        wait_eff(0, 8'h20, 220, 226);
        apb(1'b1, 8'h00, 32'h61);
        ticks(20);
        apb(1'b1, 8'h00, 32'h41);
        apb(1'b0, 8'h14, 32'h0); check({31'h0, rd[7:0] > 8'h28 && rd[7:0] < 8'h40}, 32'h1);
        wait_eff(0, 8'h20, 12, 28);
        apb(1'b1, 8'h00, 32'h01);
        apb(1'b1, 8'h04, 32'h0);
        wait_eff(0, 8'h00, 124, 132);
        // Preamp start gain: timeout select 00 first, then the code
        apb(1'b1, 8'h10, 32'h70030);
        ticks(100);
        check({25'h0, preamp_gain}, 32'h10);
        ticks(40);
        check({25'h0, preamp_gain}, 32'h30);
        apb(1'b1, 8'h10, 32'h70005);
        ticks(3);
        mic_sign <= 1'b1;
        ticks(2);
        check({25'h0, preamp_gain}, 32'h05);
        apb(1'b1, 8'h10, 32'h70105);
        ticks(260);
        apb(1'b1, 8'h10, 32'hF1505);
        apb(1'b0, 8'h14, 32'h0); check({25'h0, rd[22:16]}, 32'h05);
        check({29'h0, auto_level_enable, aux_single_ended, aux_neg_pin_en}, 32'h6);
        check({28'h0, aux_gain_code}, 32'hF);
        close_out();
    end
endmodule
`default_nettype wire
